// [bench/rlc_afe.sv]
// rlc_afe: behavioural error front end; 1 mV per reference step.
// assumes sense_mv is steady around each trigger.
`timescale 1ns/10ps
module rlc_afe
    import rlc_pkg::*;
(
    input wire logic                    clk,      // clock
    input wire logic                    trig,     // sample trigger
    input wire logic [DAC_W-1:0]        ref_dac,  // reference code
    input wire logic [1:0]              gain,     // gain code
    input wire logic signed [31:0]      sense_mv, // sensed voltage
    output logic signed [ERR_W-1:0]     err       // clipped error
);
    int e;
    initial err = '0;
    always @(posedge clk) begin
        if (trig) begin
            e = (int'(ref_dac) - sense_mv) / (8 >> gain);
            err <= (e > 31) ? ERR_MAX : (e < -32) ? ERR_MIN : ERR_W'(e);
        end
    end
endmodule // rlc_afe

// [bench/rlc_chk_assertions.sv]
// rlc_chk: port checker for rlc_rail_loop.
// assumes registers change only through the bus port.
`timescale 1ns/10ps
module rlc_chk
    import rlc_pkg::*;
#(parameter int NUM_ENG = 4) (
    input wire logic                    clk,         // clock
    input wire logic                    rst,         // reset
    input wire rlc_pkg::rlc_bus_s       bus,         // bus
    input wire logic signed [ERR_W-1:0] error_code,  // error
    input wire logic                    sync_out,    // sync out
    input wire logic [DAC_W-1:0]        ref_dac,     // reference
    input wire logic                    sample_trig, // trigger
    input wire logic [NUM_ENG-1:0]      gate_drive   // gates
);
    logic [15:0] per_reg;
    logic [15:0] cnt_reg;
    logic [1:0]  rise_reg;
    logic        en_reg;
    logic        hi_reg;
    logic        quiet_reg;
    logic        fol_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    always_ff @(posedge clk) begin
        if (rst) begin
            per_reg <= PERIOD_RST;
            en_reg <= 1'b0;
            hi_reg <= 1'b0;
            fol_reg <= 1'b0;
        end else if (bus.wr) begin
            if (bus.addr == REG_PERIOD) per_reg <= bus.wdata[15:0];
            if (bus.addr == REG_CTRL) en_reg <= bus.wdata[CTRL_EN_BIT];
            if (bus.addr == REG_SYNC_CFG) hi_reg <= bus.wdata[15:8] < 8'h04;
            if (bus.addr == REG_SYNC_CFG) fol_reg <= bus.wdata[7:0] != 8'h00;
        end
    end
    // any write may move the period, so spacing is judged only across quiet periods
    always_ff @(posedge clk) begin
        cnt_reg <= (rst || sample_trig) ? 16'h1 : cnt_reg + 16'h1;
        rise_reg <= (rst || sample_trig) ? 2'h0 : rise_reg + 2'($rose(gate_drive[0]));
        quiet_reg <= !rst && (sample_trig || (quiet_reg && !bus.wr));
    end
    a_trig_period: assert property (sample_trig && quiet_reg && !fol_reg |-> cnt_reg == per_reg)
        else $error("trigger spacing");
    a_gate_off: assert property (!en_reg && !$past(en_reg, 2) |-> gate_drive == '0)
        else $error("gate while disabled");
    a_gate_once: assert property (quiet_reg && !fol_reg |-> rise_reg < 2'h2)
        else $error("two gate pulses in a period");
    a_sync_off: assert property (!hi_reg && !$past(hi_reg) |-> !sync_out)
        else $error("sync out not disabled");
    a_sync_pulse: assert property (sync_out && !fol_reg |=> !sync_out [*8])
        else $error("sync out too long");
    a_slew_down: assert property ($past(error_code, 5) == ERR_MAX && error_code == ERR_MAX && !$past(bus.wr)
        && $changed(ref_dac) |-> ref_dac == $past(ref_dac) - 10'h1)
        else $error("reference not lowered");
    a_slew_up: assert property ($past(error_code, 5) == ERR_MIN && error_code == ERR_MIN && !$past(bus.wr)
        && $changed(ref_dac) |-> ref_dac == $past(ref_dac) + 10'h1)
        else $error("reference not raised");
    a_slew_gap: assert property ($changed(ref_dac) && !$past(bus.wr) |=> $stable(ref_dac) [*8])
        else $error("reference slews too fast");
endmodule // rlc_chk
bind rlc_rail_loop rlc_chk #(.NUM_ENG(NUM_ENG)) u_chk (.clk(clk), .rst(rst), .bus(bus),
    .error_code(error_code), .sync_out(sync_out), .ref_dac(ref_dac), .sample_trig(sample_trig),
    .gate_drive(gate_drive));

// [bench/tb.sv]
// tb: scenario bench for rlc_rail_loop.
// assumes the front end model answers each trigger.
`timescale 1ns/10ps
module tb;
    import rlc_pkg::*;
    logic clk, rst, light_load, sync_in, sync_out, sample_trig;
    rlc_bus_s bus;
    logic [DATA_W-1:0] rdata;
    logic signed [ERR_W-1:0] error_code;
    logic [DAC_W-1:0] ref_dac;
    logic [1:0] front_end_gain_code;
    logic [3:0] gate_drive;
    int sense, sc, errors, n_compared;
    bit follow;
    rlc_rail_loop u_dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .error_code(error_code),
        .light_load(light_load), .sync_in(sync_in), .sync_out(sync_out), .ref_dac(ref_dac),
        .front_end_gain_code(front_end_gain_code), .sample_trig(sample_trig), .gate_drive(gate_drive));
    rlc_afe u_afe (.clk(clk), .trig(sample_trig), .ref_dac(ref_dac), .gain(front_end_gain_code),
        .sense_mv(sense), .err(error_code));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // external sync every 30 clocks, faster than the 40-clock period
    always @(posedge clk) begin
        sc <= (sc == 29) ? 0 : sc + 1;
        sync_in <= follow && sc < 3;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk) bus <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk) bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk) bus <= '0;
        @(negedge clk) chk(rdata, e);
    endtask
    task automatic gap(input bit so, input int e);
        int n;
        do @(negedge clk); while (!(so ? sync_out : sample_trig));
        n = 0;
        do begin @(negedge clk); n++; end while (!(so ? sync_out : sample_trig));
        chk(n, e);
    endtask
    task automatic t_bank;
        logic [1:0] g [3] = '{2'h1, 2'h3, 2'h2};
        logic [2:0] c [3] = '{3'h3, 3'h1, 3'h5};
        for (int b = 0; b < 3; b++) wr(8'(REG_BANK_BASE + BANK_STRIDE * b), {30'h0, g[b]});
        for (int b = 0; b < 3; b++) begin
            wr(REG_CTRL, {29'h0, c[b]});
            repeat (50) @(posedge clk);
            @(negedge clk) chk({30'h0, front_end_gain_code}, {30'h0, g[b]});
        end
    endtask
    task automatic t_trig;
        rd(REG_SAMPLE_T, 32'ha);
        gap(1'b0, 40);
    endtask
    task automatic t_sync;
        wr(REG_SYNC_CFG, 32'h0);
        gap(1'b1, 40);
        wr(REG_SYNC_CFG, 32'h1);
        rd(REG_SYNC_CFG, 32'h1);
        rd(8'hfc, 32'h0);
        follow = 1'b1;
        repeat (70) @(posedge clk);
        gap(1'b0, 30);
        follow = 1'b0;
        wr(REG_SYNC_CFG, 32'h0400);
    endtask
    task automatic slew(input int mv, input logic [9:0] dir);
        logic [9:0] r0;
        sense = mv;
        @(negedge clk) r0 = ref_dac;
        while (ref_dac === r0) @(negedge clk);
        r0 = ref_dac;
        repeat (4 * SLEW_STEP_CYC + SLEW_STEP_CYC / 2) @(negedge clk);
        chk({22'h0, ref_dac}, {22'h0, 10'(r0 + 10'h4 * dir)});
    endtask
    task automatic t_duty;
        logic [7:0] k = REG_BANK_BASE + BANK_STRIDE;
        int n;
        sense = -16;
        wr(k + BK_LIMITS, 32'h0c043c30);
        wr(k + BK_NL_GAIN0 + 8'h10, 32'h1000);
        wr(k + BK_B0, 32'h0800);
        wr(k + BK_C0, 32'h1000);
        wr(REG_CTRL, 32'h1);
        repeat (200) @(posedge clk);
        rd(REG_DUTY, 32'h8000);
        do @(negedge clk); while (gate_drive[0]);
        do @(negedge clk); while (!gate_drive[0]);
        n = 0;
        do begin n++; @(negedge clk); end while (gate_drive[0]);
        chk(n, 20);
    endtask
    task automatic t_sat;
        wr(REG_CTRL, 32'h1);
        wr(REG_VREF, 32'h200);
        repeat (4) @(posedge clk);
        slew(0, 10'h3ff);
        slew(1000, 10'h001);
    endtask
    task automatic finish_test;
        if (errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #(100 * 20000);
        errors++;
        finish_test;
    end
    initial begin
        bus = '0;
        light_load = 1'b1;
        sync_in = 1'b0;
        sense = 0;
        sc = 0;
        rst = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        wr(REG_PERIOD, 32'd40);
        wr(REG_SAMPLE_T, 32'd10);
        t_bank;
        t_trig;
        t_sync;
        t_duty;
        t_sat;
        finish_test;
    end
endmodule // tb

// [core/rlc_compensator.sv]
// rlc_compensator: nonlinear gain, second-order iir, then first-order iir; one result per start.
// assumes coefficients stay steady while a calculation runs (a few cycles).
`timescale 1ns/10ps
module rlc_compensator
    import rlc_pkg::*;
(
    input  wire logic                    clk,       // system clock
    input  wire logic                    rst,       // sync reset, active high
    input  wire logic                    start,     // one-cycle pulse: new error sample
    input  wire logic signed [ERR_W-1:0] err,       // clipped error code
    input  wire rlc_pkg::rlc_bank_s      coef,      // active coefficient bank
    output logic        [DUTY_W-1:0]     duty,      // duty, full scale = 100 %
    output logic                         done       // one-cycle pulse: duty valid
);
    logic signed [ACC_W-1:0] e_reg, e1_reg, e2_reg, u1_reg, u2_reg, v1_reg, w1_reg;
    logic signed [ACC_W-1:0] u_next, w_next;
    logic signed [COEF_W-1:0] g;
    logic [1:0] step_reg;

    function automatic logic signed [ACC_W-1:0] mulc(input logic signed [COEF_W-1:0] c,
                                                      input logic signed [ACC_W-1:0] x);
        logic signed [ACC_W+COEF_W-1:0] p;
        p = c * x;
        mulc = ACC_W'(p >>> COEF_FRAC);
    endfunction

    // region gains: below limit0 uses gain 0, at or above limit3 gain 4
    always_comb begin
        if (err < coef.limit0)      g = coef.nl_gain0;
        else if (err < coef.limit1) g = coef.nl_gain1;
        else if (err < coef.limit2) g = coef.nl_gain2;
        else if (err < coef.limit3) g = coef.nl_gain3;
        else                        g = coef.nl_gain4;
    end

    // second-order direct form then first-order section
    always_comb begin
        u_next = mulc(coef.b0, e_reg) + mulc(coef.b1, e1_reg) + mulc(coef.b2, e2_reg)
               + mulc(coef.a1, u1_reg) + mulc(coef.a2, u2_reg);
        w_next = mulc(coef.c0, u_next) + mulc(coef.c1, v1_reg) + mulc(coef.d1, w1_reg);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            step_reg <= 2'd0;
            done     <= 1'b0;
            e_reg    <= '0;
        end else begin
            done <= 1'b0;
            case (step_reg)
                2'd0: if (start) begin
                    e_reg    <= mulc(g, ACC_W'(err) <<< COEF_FRAC);
                    step_reg <= 2'd1;
                end
                2'd1: begin
                    step_reg <= 2'd0;
                    done     <= 1'b1;
                end
                default: step_reg <= 2'd0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            e1_reg <= '0; e2_reg <= '0; u1_reg <= '0; u2_reg <= '0; v1_reg <= '0; w1_reg <= '0;
            duty   <= '0;
        end else if (step_reg == 2'd1) begin
            e1_reg <= e_reg;
            e2_reg <= e1_reg;
            u1_reg <= u_next;
            u2_reg <= u1_reg;
            v1_reg <= u_next;
            // clamp keeps duty inside 0..100 % and stops state windup
            if (w_next < 0) begin
                w1_reg <= '0;
                duty   <= '0;
            end else if (w_next > ACC_W'({DUTY_W{1'b1}})) begin
                w1_reg <= ACC_W'({DUTY_W{1'b1}});
                duty   <= '1;
            end else begin
                w1_reg <= w_next;
                duty   <= w_next[DUTY_W-1:0];
            end
        end
    end
endmodule // rlc_compensator

// [core/rlc_pkg.sv]
// rlc_pkg: shared constants, register map and carrier structs for the rail loop compensator.
// assumes a single 10 MHz system clock and a plain strobe register port.
package rlc_pkg;
    localparam int    CLK_HZ          = 10_000_000;
    localparam int    ADDR_W          = 8;
    localparam int    DATA_W          = 32;
    localparam int    ERR_W           = 6;
    localparam int    DAC_W           = 10;
    localparam int    DUTY_W          = 16;
    localparam int    PER_W           = 16;
    localparam int    COEF_W          = 16;
    localparam int    ACC_W           = 32;
    localparam int    NUM_BANKS       = 3;
    localparam int    NUM_LIMITS      = 4;
    localparam int    NUM_GAINS       = 5;
    localparam int    NUM_RAILS       = 4;

    localparam logic signed [ERR_W-1:0] ERR_MIN = -6'sd32;
    localparam logic signed [ERR_W-1:0] ERR_MAX = 6'sd31;

    // reference slew: 0.156 V/ms referred to the sense inputs, 1 mV per dac step
    localparam real   SLEW_V_PER_MS   = 0.156;
    localparam real   DAC_MV_PER_LSB  = 1.0;
    localparam int    SLEW_STEP_CYC   = int'(CLK_HZ / (SLEW_V_PER_MS * 1.0e6 / DAC_MV_PER_LSB));

    // register offsets (byte addresses, one word each)
    localparam logic [ADDR_W-1:0] REG_CTRL      = 8'h00;
    localparam logic [ADDR_W-1:0] REG_PERIOD    = 8'h04;
    localparam logic [ADDR_W-1:0] REG_SAMPLE_T  = 8'h08;
    localparam logic [ADDR_W-1:0] REG_VREF      = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_SYNC_CFG  = 8'h10;
    localparam logic [ADDR_W-1:0] REG_STATUS    = 8'h14;
    localparam logic [ADDR_W-1:0] REG_DUTY      = 8'h18;
    localparam logic [ADDR_W-1:0] REG_BANK_BASE = 8'h40;
    localparam logic [ADDR_W-1:0] BANK_STRIDE   = 8'h40;
    // offsets within a bank
    localparam logic [5:0] BK_GAIN_CODE = 6'h00;
    localparam logic [5:0] BK_LIMITS    = 6'h04;
    localparam logic [5:0] BK_NL_GAIN0  = 6'h08;
    localparam logic [5:0] BK_B0        = 6'h1c;
    localparam logic [5:0] BK_B1        = 6'h20;
    localparam logic [5:0] BK_B2        = 6'h24;
    localparam logic [5:0] BK_A1        = 6'h28;
    localparam logic [5:0] BK_A2        = 6'h2c;
    localparam logic [5:0] BK_C0        = 6'h30;
    localparam logic [5:0] BK_C1        = 6'h34;
    localparam logic [5:0] BK_D1        = 6'h38;

    // control bits
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_RAMP_BIT  = 1;
    localparam int CTRL_LIGHT_BIT = 2;
    localparam int SYNC_OUT_LSB   = 8;

    localparam logic [PER_W-1:0]  PERIOD_RST   = 16'h0064;
    localparam logic [PER_W-1:0]  SAMPLE_RST   = 16'h0032;
    localparam logic [DAC_W-1:0]  VREF_RST     = 10'h000;
    localparam logic [15:0]       SYNC_CFG_RST = 16'hff00;
    localparam int                COEF_FRAC    = 12;
    localparam int                DUTY_FRAC    = 16;

    typedef enum logic [1:0] {
        RLC_BANK_RAMP  = 2'd0,
        RLC_BANK_REG   = 2'd1,
        RLC_BANK_LIGHT = 2'd2
    } rlc_bank_e;

    typedef struct packed {
        logic [1:0]                  gain_code;
        logic signed [ERR_W-1:0]     limit0;
        logic signed [ERR_W-1:0]     limit1;
        logic signed [ERR_W-1:0]     limit2;
        logic signed [ERR_W-1:0]     limit3;
        logic signed [COEF_W-1:0]    nl_gain0;
        logic signed [COEF_W-1:0]    nl_gain1;
        logic signed [COEF_W-1:0]    nl_gain2;
        logic signed [COEF_W-1:0]    nl_gain3;
        logic signed [COEF_W-1:0]    nl_gain4;
        logic signed [COEF_W-1:0]    b0;
        logic signed [COEF_W-1:0]    b1;
        logic signed [COEF_W-1:0]    b2;
        logic signed [COEF_W-1:0]    a1;
        logic signed [COEF_W-1:0]    a2;
        logic signed [COEF_W-1:0]    c0;
        logic signed [COEF_W-1:0]    c1;
        logic signed [COEF_W-1:0]    d1;
    } rlc_bank_s;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } rlc_bus_s;
endpackage

// [core/rlc_pulse_engine.sv]
// rlc_pulse_engine: period counter, compare threshold and gate drive for one engine.
// assumes period >= 2 and duty updates come as one-cycle pulses.
`timescale 1ns/10ps
module rlc_pulse_engine
    import rlc_pkg::*;
(
    input  wire logic              clk,        // system clock
    input  wire logic              rst,        // sync reset, active high
    input  wire logic [PER_W-1:0]  period,     // switching period in clocks
    input  wire logic [PER_W-1:0]  sample_t,   // sample point within period
    input  wire logic [DUTY_W-1:0] duty,       // new duty value
    input  wire logic              duty_vld,   // duty pulse
    input  wire logic              restart,    // restart counter now (sync follow)
    output logic                   gate,       // gate drive
    output logic                   sample,     // one-cycle sample trigger
    output logic                   boundary    // one-cycle period restart
);
    logic [PER_W-1:0]  cnt_reg;
    logic [PER_W-1:0]  thr_reg;
    logic [DUTY_W-1:0] pend_reg;
    logic [PER_W+DUTY_W-1:0] prod;
    logic wrap;

    assign wrap = restart || (cnt_reg >= period - 16'h0001);
    assign prod = duty_pend_mul(pend_reg, period);

    function automatic logic [PER_W+DUTY_W-1:0] duty_pend_mul(input logic [DUTY_W-1:0] d,
                                                              input logic [PER_W-1:0] p);
        duty_pend_mul = d * p;
    endfunction

    always_ff @(posedge clk) begin
        if (rst) cnt_reg <= '0;
        else if (wrap) cnt_reg <= '0;
        else cnt_reg <= cnt_reg + 16'h0001;
    end

    always_ff @(posedge clk) begin
        if (rst) pend_reg <= '0;
        else if (duty_vld) pend_reg <= duty;
    end

    // threshold only moves at the period boundary so a pulse is never cut mid-period
    always_ff @(posedge clk) begin
        if (rst) thr_reg <= '0;
        else if (wrap) thr_reg <= prod[PER_W+DUTY_W-1:DUTY_FRAC];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            gate     <= 1'b0;
            sample   <= 1'b0;
            boundary <= 1'b0;
        end else begin
            gate     <= wrap ? (prod[PER_W+DUTY_W-1:DUTY_FRAC] != '0)
                             : (cnt_reg + 16'h0001 < thr_reg);
            sample   <= !wrap && (cnt_reg == sample_t);
            boundary <= wrap;
        end
    end
endmodule // rlc_pulse_engine

// [core/rlc_rail_loop.sv]
// rlc_rail_loop: one rail's digital voltage loop with register port and four pulse engines.
// assumes the error converter delivers a clipped 6-bit code a cycle after its trigger.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module rlc_rail_loop
    import rlc_pkg::*;
#(
    parameter int NUM_ENG = NUM_RAILS               // pulse engines in this block
) (
    input  wire logic                    clk,          // system clock
    input  wire logic                    rst,          // sync reset, active high
    input  wire rlc_pkg::rlc_bus_s       bus,          // register strobes, address, data
    output logic        [DATA_W-1:0]     rdata,        // read data, cycle after read
    input  wire logic signed [ERR_W-1:0] error_code,   // error converter result
    input  wire logic                    light_load,   // measured current below threshold
    input  wire logic                    sync_in,      // external sync pin
    output logic                         sync_out,     // sync output pin
    output logic        [DAC_W-1:0]      ref_dac,      // reference dac code
    output logic        [1:0]            front_end_gain_code, // analog front end gain
    output logic                         sample_trig,  // error converter sample trigger
    output logic        [NUM_ENG-1:0]    gate_drive    // gate drive outputs
);
    logic [PER_W-1:0]  period_reg, sample_t_reg;
    logic [DAC_W-1:0]  vref_set_reg, vref_reg;
    logic [15:0]       sync_cfg_reg;
    logic [2:0]        ctrl_reg;
    rlc_bank_s         bank_reg [NUM_BANKS];
    rlc_bank_s         act;
    rlc_bank_e         bank_sel;
    logic signed [ERR_W-1:0] err_reg;
    logic              err_vld_reg, trig_d_reg;
    logic              sat_hi_reg, sat_lo_reg;
    logic [15:0]       slew_cnt_reg;
    logic [2:0]        sync_sh_reg;
    logic              sync_lvl_reg, sync_rise;
    logic [DUTY_W-1:0] duty;
    logic              duty_vld;
    logic [NUM_ENG-1:0] eng_gate, eng_sample, eng_bnd, eng_restart;
    logic [DATA_W-1:0] rd_mux;
    logic [1:0]        wbank;
    logic [5:0]        woff;

    // bank window decode, used by the read path only; writes decode the window through wbank
    function automatic logic bank_hit(input logic [ADDR_W-1:0] a, input logic [1:0] b);
        // window index decode: an 8-bit upper bound would wrap to zero for the last bank
        bank_hit = (a[7:6] == 2'(b + 2'd1));
    endfunction

    assign woff  = bus.addr[5:0];
    assign wbank = 2'(bus.addr[7:6] - 2'd1);

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg     <= 3'h0;
            period_reg   <= PERIOD_RST;
            sample_t_reg <= SAMPLE_RST;
            vref_set_reg <= VREF_RST;
            sync_cfg_reg <= SYNC_CFG_RST;
        end else if (bus.wr) begin
            case (bus.addr)
                REG_CTRL:     ctrl_reg     <= bus.wdata[2:0];
                REG_PERIOD:   period_reg   <= bus.wdata[PER_W-1:0];
                REG_SAMPLE_T: sample_t_reg <= bus.wdata[PER_W-1:0];
                REG_VREF:     vref_set_reg <= bus.wdata[DAC_W-1:0];
                REG_SYNC_CFG: sync_cfg_reg <= bus.wdata[15:0];
                default: ;
            endcase
        end
    end

    // coefficient banks, written through the bank windows
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int b = 0; b < NUM_BANKS; b++) bank_reg[b] <= '0;
        end else if (bus.wr && bus.addr >= REG_BANK_BASE && int'(wbank) < NUM_BANKS) begin
            case (woff)
                BK_GAIN_CODE: bank_reg[wbank].gain_code <= bus.wdata[1:0];
                BK_LIMITS: begin
                    bank_reg[wbank].limit0 <= bus.wdata[5:0];
                    bank_reg[wbank].limit1 <= bus.wdata[13:8];
                    bank_reg[wbank].limit2 <= bus.wdata[21:16];
                    bank_reg[wbank].limit3 <= bus.wdata[29:24];
                end
                BK_NL_GAIN0:         bank_reg[wbank].nl_gain0 <= bus.wdata[COEF_W-1:0];
                BK_NL_GAIN0 + 6'h04: bank_reg[wbank].nl_gain1 <= bus.wdata[COEF_W-1:0];
                BK_NL_GAIN0 + 6'h08: bank_reg[wbank].nl_gain2 <= bus.wdata[COEF_W-1:0];
                BK_NL_GAIN0 + 6'h0c: bank_reg[wbank].nl_gain3 <= bus.wdata[COEF_W-1:0];
                BK_NL_GAIN0 + 6'h10: bank_reg[wbank].nl_gain4 <= bus.wdata[COEF_W-1:0];
                BK_B0: bank_reg[wbank].b0 <= bus.wdata[COEF_W-1:0];
                BK_B1: bank_reg[wbank].b1 <= bus.wdata[COEF_W-1:0];
                BK_B2: bank_reg[wbank].b2 <= bus.wdata[COEF_W-1:0];
                BK_A1: bank_reg[wbank].a1 <= bus.wdata[COEF_W-1:0];
                BK_A2: bank_reg[wbank].a2 <= bus.wdata[COEF_W-1:0];
                BK_C0: bank_reg[wbank].c0 <= bus.wdata[COEF_W-1:0];
                BK_C1: bank_reg[wbank].c1 <= bus.wdata[COEF_W-1:0];
                BK_D1: bank_reg[wbank].d1 <= bus.wdata[COEF_W-1:0];
                default: ;
            endcase
        end
    end

    // ramp wins over light load: a soft start at light current still needs ramp tuning
    always_comb begin
        if (ctrl_reg[CTRL_RAMP_BIT])                      bank_sel = RLC_BANK_RAMP;
        else if (ctrl_reg[CTRL_LIGHT_BIT] && light_load)  bank_sel = RLC_BANK_LIGHT;
        else                                              bank_sel = RLC_BANK_REG;
        act = bank_reg[bank_sel];
    end

    always_ff @(posedge clk) begin
        if (rst) front_end_gain_code <= 2'd0;
        else     front_end_gain_code <= act.gain_code;
    end

    // the converter samples in the cycle after the trigger
    always_ff @(posedge clk) begin
        if (rst) begin
            trig_d_reg  <= 1'b0;
            err_reg     <= '0;
            err_vld_reg <= 1'b0;
        end else begin
            trig_d_reg  <= sample_trig;
            err_vld_reg <= trig_d_reg && ctrl_reg[CTRL_EN_BIT];
            if (trig_d_reg) err_reg <= error_code;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sat_hi_reg <= 1'b0;
            sat_lo_reg <= 1'b0;
        end else if (err_vld_reg) begin
            sat_hi_reg <= (err_reg == ERR_MAX);
            sat_lo_reg <= (err_reg == ERR_MIN);
        end
    end

    // error = ref - sense: clipped high means sense is low, so lower the reference
    always_ff @(posedge clk) begin
        if (rst) begin
            vref_reg     <= VREF_RST;
            slew_cnt_reg <= '0;
        end else if (!(sat_hi_reg || sat_lo_reg)) begin
            vref_reg     <= vref_set_reg;
            slew_cnt_reg <= '0;
        end else if (slew_cnt_reg >= 16'(SLEW_STEP_CYC - 1)) begin
            slew_cnt_reg <= '0;
            if (sat_hi_reg && vref_reg != '0)    vref_reg <= vref_reg - 10'h001;
            else if (sat_lo_reg && vref_reg != '1) vref_reg <= vref_reg + 10'h001;
        end else begin
            slew_cnt_reg <= slew_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) ref_dac <= VREF_RST;
        else     ref_dac <= vref_reg;
    end

    // sync pin: three stages, a level counts once the last two agree
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_sh_reg  <= 3'h0;
            sync_lvl_reg <= 1'b0;
        end else begin
            sync_sh_reg <= {sync_sh_reg[1:0], sync_in};
            if (sync_sh_reg[2] == sync_sh_reg[1]) sync_lvl_reg <= sync_sh_reg[2];
        end
    end
    assign sync_rise = (sync_sh_reg[2] == sync_sh_reg[1]) && sync_sh_reg[2] && !sync_lvl_reg;

    rlc_compensator u_comp (
        .clk   (clk),
        .rst   (rst),
        .start (err_vld_reg),
        .err   (err_reg),
        .coef  (act),
        .duty  (duty),
        .done  (duty_vld)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NUM_ENG; gi++) begin : g_eng
            assign eng_restart[gi] = sync_rise && sync_cfg_reg[gi];
            rlc_pulse_engine u_eng (
                .clk      (clk),
                .rst      (rst),
                .period   (period_reg),
                .sample_t (sample_t_reg),
                .duty     (duty),
                .duty_vld (duty_vld),
                .restart  (eng_restart[gi]),
                .gate     (eng_gate[gi]),
                .sample   (eng_sample[gi]),
                .boundary (eng_bnd[gi])
            );
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            gate_drive  <= '0;
            sample_trig <= 1'b0;
            sync_out    <= 1'b0;
        end else begin
            gate_drive  <= eng_gate & {NUM_ENG{ctrl_reg[CTRL_EN_BIT]}};
            sample_trig <= eng_sample[0];
            sync_out    <= (int'(sync_cfg_reg[15:SYNC_OUT_LSB]) < NUM_ENG)
                         ? eng_bnd[sync_cfg_reg[SYNC_OUT_LSB+1:SYNC_OUT_LSB]] : 1'b0;
        end
    end

    always_comb begin
        rd_mux = '0;
        case (bus.addr)
            REG_CTRL:     rd_mux = {29'h0, ctrl_reg};
            REG_PERIOD:   rd_mux = {16'h0, period_reg};
            REG_SAMPLE_T: rd_mux = {16'h0, sample_t_reg};
            REG_VREF:     rd_mux = {22'h0, vref_set_reg};
            REG_SYNC_CFG: rd_mux = {16'h0, sync_cfg_reg};
            REG_STATUS:   rd_mux = {16'h0, 6'(err_reg), vref_reg[5:0], bank_sel, sat_lo_reg, sat_hi_reg};
            REG_DUTY:     rd_mux = {16'h0, duty};
            default: begin
                for (int b = 0; b < NUM_BANKS; b++)
                    if (bank_hit(bus.addr, 2'(b)) && bus.addr[5:0] == BK_GAIN_CODE)
                        rd_mux = {30'h0, bank_reg[b].gain_code};
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst)         rdata <= '0;
        else if (bus.rd) rdata <= rd_mux;
        else             rdata <= '0;
    end
endmodule // rlc_rail_loop
